// ===== pkg/sblb_pkg.sv
package sblb_pkg;

    // register byte offsets
    localparam logic [7:0] OFF_LANE_CFG  = 8'h30;
    localparam logic [7:0] OFF_GEN_CTL   = 8'h34;
    localparam logic [7:0] OFF_UDP_LO    = 8'h38;
    localparam logic [7:0] OFF_INS_LO    = 8'h3c;
    localparam logic [7:0] OFF_ENLOW     = 8'h40;
    localparam logic [7:0] OFF_DELAY     = 8'h44;
    localparam logic [7:0] OFF_CAL_ERR   = 8'h48;
    localparam logic [7:0] OFF_CAL_SEL   = 8'h4c;

    // lane configuration word field positions
    localparam int POS_PREAM0_LO   = 24;
    localparam int POS_RX_CE       = 23;
    localparam int POS_TX_CE       = 22;
    localparam int POS_PRBS_LEN    = 19;
    localparam int POS_SRC         = 18;
    localparam int POS_BYTE_MODE   = 16;
    // generator control word field positions
    localparam int POS_INS_COUNT   = 28;
    localparam int POS_SEND_PREAM  = 27;
    localparam int POS_PREAM1      = 8;
    localparam int POS_GEN_EN      = 7;
    localparam int POS_GEN_WORD    = 6;
    localparam int POS_GEN_RST_N   = 5;
    localparam int POS_SPAN        = 2;
    localparam int POS_PREAM0_HI   = 0;
    // calibration override and delay word field positions
    localparam int POS_CAL_LATCH   = 29;
    localparam int POS_CAL_DATA    = 17;
    localparam int POS_CAL_EN      = 16;
    localparam int POS_DELAY       = 16;

    // reset values
    localparam logic [31:0] RST_WORD    = 32'h0000_0000;
    localparam logic [15:0] RST_ERR_CNT = 16'h0000;

    // pattern lengths
    localparam logic [2:0] PRBS7  = 3'h0;
    localparam logic [2:0] PRBS15 = 3'h1;
    localparam logic [2:0] PRBS23 = 3'h2;
    localparam logic [2:0] PRBS31 = 3'h3;

    // settings shared by generator and checker
    typedef struct packed {
        logic        byte_mode;
        logic        dbl_word;
        logic        src_prbs;
        logic        send_pream;
        logic [2:0]  prbs_len;
        logic [2:0]  span;
        logic [2:0]  ins_count;
        logic [11:0] ins_delay;
        logic [39:0] udp;
        logic [39:0] ins_word;
        logic [9:0]  pream0;
        logic [9:0]  pream1;
    } sblb_cfg_type;

    // running state of one pattern engine
    typedef struct packed {
        logic [4:0]  ins_left;
        logic [1:0]  ins_pos;
        logic [11:0] delay_cnt;
        logic [2:0]  udp_idx;
        logic        pream_sel;
        logic [30:0] lfsr;
    } sblb_eng_type;

    localparam logic [30:0] LFSR_SEED = 31'h7fff_ffff;

endpackage

// ===== hw/sblb_bist_lane.sv
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/1ps
module sblb_bist_lane
    import sblb_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              mclk_i,
    input  wire logic              rst_b_i,
    input  wire logic [ADDR_W-1:0] avs_address_i,
    input  wire logic              avs_read_i,
    input  wire logic              avs_write_i,
    input  wire logic [31:0]       avs_writedata_i,
    input  wire logic [3:0]        avs_byteenable_i,
    output logic      [31:0]       avs_readdata_o,
    output logic                   avs_waitrequest_o,
    input  wire logic              tx_slot_i,
    output logic      [19:0]       tx_data_o,
    output logic      [1:0]        tx_k_o,
    output logic                   tx_valid_o,
    output logic                   tx_oe_o,
    input  wire logic              rx_valid_i,
    input  wire logic [19:0]       rx_data_i,
    input  wire logic [1:0]        rx_k_i,
    input  wire logic [7:0]        cal_value_i,
    output logic      [7:0]        cal_value_o,
    output logic      [2:0]        cal_sel_o,
    output logic                   cal_ovr_en_o,
    output logic                   cal_latch_o
);

    // whole module state
    typedef struct packed {
        logic [31:0]  lane_cfg;
        logic [31:0]  gen_ctl;
        logic [39:0]  udp;
        logic [39:0]  ins_word;
        logic [15:0]  en_low;
        logic [15:0]  en_high;
        logic [11:0]  ins_delay;
        logic         cal_latch;
        logic [11:0]  cal_data;
        logic         cal_en;
        logic [2:0]   cal_sel;
        logic [15:0]  err_cnt;
        sblb_eng_type gen;
        sblb_eng_type chk;
        logic         oe_phase_hi;
        logic [15:0]  oe_cnt;
        logic [19:0]  tx_data;
        logic [1:0]   tx_k;
        logic         tx_valid;
        logic         tx_oe;
        logic [7:0]   cal_value;
        logic [31:0]  rdata;
        logic         wait_req;
    } sblb_state_type;

    sblb_state_type st_q;
    sblb_state_type st_d;

    // elaboration check: the decoder always reads eight address bits
    if (ADDR_W < 8) begin
        $error("sblb_bist_lane: ADDR_W must be at least 8");
    end

    // one pattern unit from the engine, shared by both directions
    function automatic void eng_step(input sblb_eng_type e_in, input sblb_cfg_type c,
                                     output sblb_eng_type e_out, output logic [9:0] unit);
        logic [4:0] total;
        logic       ins_on;
        logic       fb;
        int         nbits;
        e_out  = e_in;
        unit   = 10'h000;
        total  = 5'(c.span * c.ins_count);
        ins_on = (c.span != 3'h0) && (c.span <= 3'h4) && (c.ins_count != 3'h0);
        nbits  = c.byte_mode ? 8 : 10;
        fb     = 1'b0;
        if (e_in.ins_left != 5'h00) begin
            // insertion unit from the low end of the insertion word
            unit = c.ins_word[10*int'(e_in.ins_pos) +: 10];
            e_out.ins_left = e_in.ins_left - 5'h01;
            e_out.ins_pos  = ({1'b0, e_in.ins_pos} + 3'h1 == c.span) ? 2'h0 : e_in.ins_pos + 2'h1;
        end else begin
            if (c.send_pream) begin
                unit = e_in.pream_sel ? c.pream1 : c.pream0;
                e_out.pream_sel = ~e_in.pream_sel;
            end else if (!c.src_prbs) begin
                if (c.byte_mode) begin
                    unit = {2'b00, c.udp[8*int'(e_in.udp_idx) +: 8]};
                    e_out.udp_idx = (e_in.udp_idx == 3'h4) ? 3'h0 : e_in.udp_idx + 3'h1;
                end else begin
                    unit = c.udp[10*int'(e_in.udp_idx[1:0]) +: 10];
                    e_out.udp_idx = (e_in.udp_idx >= 3'h3) ? 3'h0 : e_in.udp_idx + 3'h1;
                end
            end else begin
                // serial lfsr stepped once per bit of the unit
                for (int b = 0; b < 10; b++) begin
                    if (b < nbits) begin
                        unique case (c.prbs_len)
                            PRBS7:   fb = e_out.lfsr[6] ^ e_out.lfsr[5];
                            PRBS15:  fb = e_out.lfsr[14] ^ e_out.lfsr[13];
                            PRBS23:  fb = e_out.lfsr[22] ^ e_out.lfsr[17];
                            default: fb = e_out.lfsr[30] ^ e_out.lfsr[27];
                        endcase
                        unit[b]    = fb;
                        e_out.lfsr = {e_out.lfsr[29:0], fb};
                    end
                end
            end
            // spacing counted in units, during preamble and data alike
            if (ins_on) begin
                // nonzero delay d leaves exactly d units between insertions, so even d keeps double words aligned when span times ins_count is even
                if ((e_in.delay_cnt + 12'h001) >= c.ins_delay) begin
                    e_out.ins_left  = total;
                    e_out.ins_pos   = 2'h0;
                    e_out.delay_cnt = 12'h000;
                end else begin
                    e_out.delay_cnt = e_in.delay_cnt + 12'h001;
                end
            end
        end
        if (c.byte_mode && !(e_in.ins_left != 5'h00 || c.send_pream)) begin
            unit[9:8] = 2'b00; // no K flag on pattern bytes
        end
    endfunction

    localparam sblb_eng_type ENG_IDLE = '{ins_left: 5'h00, ins_pos: 2'h0, delay_cnt: 12'h000,
                                         udp_idx: 3'h0, pream_sel: 1'b0, lfsr: LFSR_SEED};

    sblb_cfg_type cfg;
    logic         hit;
    logic [31:0]  rd_val;
    logic [31:0]  wmask;

    // configuration seen by both engines
    always_comb begin
        cfg.byte_mode  = st_q.lane_cfg[POS_BYTE_MODE];
        cfg.dbl_word   = st_q.gen_ctl[POS_GEN_WORD];
        cfg.src_prbs   = st_q.lane_cfg[POS_SRC];
        cfg.send_pream = st_q.gen_ctl[POS_SEND_PREAM];
        cfg.prbs_len   = st_q.lane_cfg[POS_PRBS_LEN +: 3];
        cfg.span       = st_q.gen_ctl[POS_SPAN +: 3];
        cfg.ins_count  = st_q.gen_ctl[POS_INS_COUNT +: 3];
        cfg.ins_delay  = st_q.ins_delay;
        cfg.udp        = st_q.udp;
        cfg.ins_word   = st_q.ins_word;
        cfg.pream0     = {st_q.gen_ctl[POS_PREAM0_HI +: 2], st_q.lane_cfg[POS_PREAM0_LO +: 8]};
        cfg.pream1     = st_q.gen_ctl[POS_PREAM1 +: 10];
    end

    // address decode and read mux; unmapped reads give zero
    always_comb begin
        hit    = 1'b1;
        rd_val = RST_WORD;
        unique case (avs_address_i[7:0])
            OFF_LANE_CFG: rd_val = st_q.lane_cfg;
            OFF_GEN_CTL:  rd_val = st_q.gen_ctl;
            OFF_UDP_LO:   rd_val = st_q.udp[31:0];
            OFF_INS_LO:   rd_val = {st_q.ins_word[23:0], st_q.udp[39:32]};
            OFF_ENLOW:    rd_val = {st_q.en_low, st_q.ins_word[39:24]};
            OFF_DELAY:    rd_val = {4'h0, st_q.ins_delay, st_q.en_high};
            OFF_CAL_ERR:  rd_val = {2'b00, st_q.cal_latch, st_q.cal_data, st_q.cal_en, st_q.err_cnt};
            OFF_CAL_SEL:  rd_val = {29'h0000_0000, st_q.cal_sel};
            default:      hit    = 1'b0;
        endcase
        if (ADDR_W > 8) begin
            if (32'(avs_address_i) >= 32'h0000_0100) begin
                hit    = 1'b0;
                rd_val = RST_WORD;
            end
        end
        for (int i = 0; i < 4; i++) begin
            wmask[8*i +: 8] = {8{avs_byteenable_i[i]}};
        end
    end

    // next state
    always_comb begin
        logic [31:0]  wv;
        logic         gen_run;
        logic         chk_run;
        logic [9:0]   u0;
        logic [9:0]   u1;
        logic [9:0]   e0;
        logic [9:0]   e1;
        logic [19:0]  exp_data;
        logic [1:0]   exp_k;
        logic [19:0]  cmp_mask;
        sblb_eng_type g1;
        sblb_eng_type g2;
        sblb_eng_type c1;
        sblb_eng_type c2;
        st_d     = st_q;
        u0       = 10'h000;
        u1       = 10'h000;
        e0       = 10'h000;
        e1       = 10'h000;
        g1       = st_q.gen;
        g2       = st_q.gen;
        c1       = st_q.chk;
        c2       = st_q.chk;
        exp_data = 20'h00000;
        exp_k    = 2'b00;
        cmp_mask = 20'h00000;
        wv       = 32'h0000_0000;
        gen_run  = st_q.gen_ctl[POS_GEN_RST_N] && st_q.gen_ctl[POS_GEN_EN];
        chk_run  = st_q.gen_ctl[POS_GEN_RST_N] && st_q.lane_cfg[POS_RX_CE];

        // bus slave: answer one cycle after the request, commit on the low waitrequest
        if ((avs_read_i || avs_write_i) && st_q.wait_req) begin
            st_d.wait_req = 1'b0;
            st_d.rdata    = avs_read_i ? rd_val : RST_WORD;
        end else if (!st_q.wait_req) begin
            st_d.wait_req = 1'b1;
            st_d.rdata    = RST_WORD; // read data only stands in the answer cycle
        end
        if (avs_write_i && !st_q.wait_req && hit) begin
            unique case (avs_address_i[7:0])
                OFF_LANE_CFG: begin
                    wv = (st_q.lane_cfg & ~wmask) | (avs_writedata_i & wmask);
                    st_d.lane_cfg = wv & 32'hfffd_0000; // bit 17 and low half held zero
                end
                OFF_GEN_CTL: begin
                    wv = (st_q.gen_ctl & ~wmask) | (avs_writedata_i & wmask);
                    st_d.gen_ctl = wv & 32'h7803_ffff;
                end
                OFF_UDP_LO: begin
                    wv = (st_q.udp[31:0] & ~wmask) | (avs_writedata_i & wmask);
                    st_d.udp[31:0] = wv;
                end
                OFF_INS_LO: begin
                    wv = ({st_q.ins_word[23:0], st_q.udp[39:32]} & ~wmask) | (avs_writedata_i & wmask);
                    st_d.udp[39:32]     = wv[7:0];
                    st_d.ins_word[23:0] = wv[31:8];
                end
                OFF_ENLOW: begin
                    wv = ({st_q.en_low, st_q.ins_word[39:24]} & ~wmask) | (avs_writedata_i & wmask);
                    st_d.ins_word[39:24] = wv[15:0];
                    st_d.en_low          = wv[31:16];
                end
                OFF_DELAY: begin
                    wv = ({4'h0, st_q.ins_delay, st_q.en_high} & ~wmask) | (avs_writedata_i & wmask);
                    st_d.en_high   = wv[15:0];
                    st_d.ins_delay = wv[POS_DELAY +: 12];
                end
                OFF_CAL_ERR: begin
                    wv = ({2'b00, st_q.cal_latch, st_q.cal_data, st_q.cal_en, 16'h0000} & ~wmask)
                         | (avs_writedata_i & wmask);
                    st_d.cal_en    = wv[POS_CAL_EN];
                    st_d.cal_data  = wv[POS_CAL_DATA +: 12];
                    st_d.cal_latch = wv[POS_CAL_LATCH];
                end
                default: begin
                    wv = (32'(st_q.cal_sel) & ~wmask) | (avs_writedata_i & wmask);
                    st_d.cal_sel = wv[2:0];
                end
            endcase
        end

        // transmit generator, one or two units per word slot
        if (!gen_run) begin
            st_d.gen      = ENG_IDLE;
            st_d.tx_valid = 1'b0;
            st_d.tx_oe    = 1'b0;
            st_d.oe_cnt   = 16'h0000;
            st_d.oe_phase_hi = 1'b0;
            st_d.tx_data  = 20'h00000;
            st_d.tx_k     = 2'b00;
        end else if (tx_slot_i && st_q.lane_cfg[POS_TX_CE]) begin
            eng_step(st_q.gen, cfg, g1, u0);
            g2 = g1;
            if (cfg.dbl_word) begin
                eng_step(g1, cfg, g2, u1);
            end
            st_d.gen      = g2;
            st_d.tx_valid = 1'b1;
            if (cfg.byte_mode) begin
                st_d.tx_data = {4'h0, u1[7:0], u0[7:0]};
                st_d.tx_k    = {u1[8], u0[8]};
            end else begin
                st_d.tx_data = {u1, u0};
                st_d.tx_k    = 2'b00;
            end
            // output enable duty pattern, counted in words
            if (st_q.en_low == 16'h0000) begin
                st_d.tx_oe = 1'b1;
            end else if (!st_q.oe_phase_hi) begin
                st_d.tx_oe = 1'b0;
                if (st_q.oe_cnt + 16'h0001 >= st_q.en_low) begin
                    st_d.oe_phase_hi = (st_q.en_high != 16'h0000);
                    st_d.oe_cnt      = 16'h0000;
                end else begin
                    st_d.oe_cnt = st_q.oe_cnt + 16'h0001;
                end
            end else begin
                st_d.tx_oe = 1'b1;
                if (st_q.oe_cnt + 16'h0001 >= st_q.en_high) begin
                    st_d.oe_phase_hi = 1'b0;
                    st_d.oe_cnt      = 16'h0000;
                end else begin
                    st_d.oe_cnt = st_q.oe_cnt + 16'h0001;
                end
            end
        end else begin
            st_d.tx_valid = 1'b0;
        end

        // receive checker follows the same engine and compares each word
        if (!chk_run) begin
            st_d.chk = ENG_IDLE;
            if (!st_q.gen_ctl[POS_GEN_RST_N]) begin
                st_d.err_cnt = RST_ERR_CNT;
            end
        end else if (rx_valid_i) begin
            eng_step(st_q.chk, cfg, c1, e0);
            c2 = c1;
            if (cfg.dbl_word) begin
                eng_step(c1, cfg, c2, e1);
            end
            st_d.chk = c2;
            if (cfg.byte_mode) begin
                exp_data = {4'h0, e1[7:0], e0[7:0]};
                exp_k    = {e1[8], e0[8]};
                cmp_mask = cfg.dbl_word ? 20'h0ffff : 20'h000ff;
            end else begin
                exp_data = {e1, e0};
                cmp_mask = cfg.dbl_word ? 20'hfffff : 20'h003ff;
            end
            if ((((rx_data_i ^ exp_data) & cmp_mask) != 20'h00000)
                || (cfg.byte_mode && ((rx_k_i ^ exp_k) & {cfg.dbl_word, 1'b1}) != 2'b00)) begin
                if (st_q.err_cnt != 16'hffff) begin
                    st_d.err_cnt = st_q.err_cnt + 16'h0001;
                end
            end
        end

        // calibration override; only the low byte reaches the front end
        // follows the enable in the same cycle, so value and enable flops never disagree
        st_d.cal_value = st_d.cal_en ? st_d.cal_data[7:0] : cal_value_i;
    end

    // state register
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_q          <= '0;
            st_q.gen.lfsr <= LFSR_SEED;
            st_q.chk.lfsr <= LFSR_SEED;
            st_q.wait_req <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs straight from the state flops
    assign avs_readdata_o    = st_q.rdata;
    assign avs_waitrequest_o = st_q.wait_req;
    assign tx_data_o         = st_q.tx_data;
    assign tx_k_o            = st_q.tx_k;
    assign tx_valid_o        = st_q.tx_valid;
    assign tx_oe_o           = st_q.tx_oe;
    assign cal_value_o       = st_q.cal_value;
    assign cal_sel_o         = st_q.cal_sel;
    assign cal_ovr_en_o      = st_q.cal_en;
    assign cal_latch_o       = st_q.cal_latch;

endmodule

// ===== tb/sblb_bist_lane_props.sv
`timescale 1ns/1ps
module sblb_bist_lane_props (
    input wire logic        mclk_i,
    input wire logic        rst_b_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic        tx_slot_i,
    input wire logic [19:0] tx_data_o,
    input wire logic [1:0]  tx_k_o,
    input wire logic        tx_valid_o,
    input wire logic [7:0]  cal_value_i,
    input wire logic [7:0]  cal_value_o,
    input wire logic        cal_ovr_en_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);

    // a taken request sees one low cycle, then idle again
    sequence s_answer;
        !avs_waitrequest_o ##1 avs_waitrequest_o;
    endsequence

    // bus handshake shape
    AST_BUS_ANSWER: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |-> ##[1:2] s_answer)
        else $error("bus request not answered");
    AST_ANSWER_NEEDS_REQ: assert property (!avs_waitrequest_o |-> (avs_read_i || avs_write_i))
        else $error("answer without request");
    AST_RDATA_IDLE_ZERO: assert property (avs_waitrequest_o |-> avs_readdata_o == 32'h0)
        else $error("read data not zero outside answer");
    AST_ONE_LOW_CYCLE: assert property ($fell(avs_waitrequest_o) |=> avs_waitrequest_o)
        else $error("waitrequest low too long");
    // word stream
    AST_VALID_NEEDS_SLOT: assert property (tx_valid_o |-> $past(tx_slot_i))
        else $error("word without slot");
    AST_K_IN_BYTE_MODE: assert property (tx_k_o != 2'b00 |-> tx_data_o[19:16] == 4'h0)
        else $error("k flag outside byte layout");
    // calibration path: bypass is one cycle late, override holds between writes
    AST_CAL_BYPASS: assert property (!cal_ovr_en_o && $past(rst_b_i) |-> cal_value_o == $past(cal_value_i))
        else $error("calibration bypass wrong");
    AST_CAL_OVR_HOLDS: assert property (cal_ovr_en_o && $past(cal_ovr_en_o) && $past(avs_waitrequest_o) &&
        $past(avs_waitrequest_o, 2) |-> $stable(cal_value_o))
        else $error("override value moved");
endmodule

bind sblb_bist_lane sblb_bist_lane_props sblb_bist_lane_props_inst (
    .mclk_i, .rst_b_i, .avs_read_i, .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .tx_slot_i,
    .tx_data_o, .tx_k_o, .tx_valid_o, .cal_value_i, .cal_value_o, .cal_ovr_en_o
);

// ===== tb/sblb_lane_model.sv
`timescale 1ns/1ps
module sblb_lane_model (
    input  wire logic        mclk_i,
    input  wire logic        rst_b_i,
    input  wire logic        slow_i,
    input  wire logic        corrupt_i,
    input  wire logic [19:0] tx_data_i,
    input  wire logic [1:0]  tx_k_i,
    input  wire logic        tx_valid_i,
    input  wire logic        tx_oe_i,
    output logic             tx_slot_o,
    output logic             rx_valid_o,
    output logic [19:0]      rx_data_o,
    output logic [1:0]       rx_k_o
);
    logic [22:0] words[$];

    // slots every cycle or every other one; words loop back to the receiver
    always @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tx_slot_o  <= 1'b0;
            rx_valid_o <= 1'b0;
            rx_data_o  <= 20'h0;
            rx_k_o     <= 2'h0;
        end else begin
            tx_slot_o  <= slow_i ? !tx_slot_o : 1'b1;
            rx_valid_o <= tx_valid_i;
            // idle lines invert, so a stale copy can never pass as data
            rx_data_o  <= tx_valid_i ? tx_data_i ^ {19'h0, corrupt_i} : ~rx_data_o;
            rx_k_o     <= tx_valid_i ? tx_k_i : ~rx_k_o;
            if (tx_valid_i) begin
                words.push_back({tx_oe_i, tx_k_i, tx_data_i});
            end
        end
    end
endmodule

// ===== tb/sblb_bist_lane_tb_top.sv
`timescale 1ns/1ps
module sblb_bist_lane_tb_top
    import sblb_pkg::*;
;
    localparam logic [39:0] UDP = 40'hc3_5a96_0f1e;
    localparam logic [39:0] INS = 40'h12_3456_789a;
    localparam logic [7:0] OFFS [6] = '{8'h38, 8'h3c, 8'h40, 8'h44, 8'h48, 8'h80};
    logic        mclk_i;
    logic        rst_b_i = 1'b0;
    logic [7:0]  avs_address_i = 8'h0;
    logic        avs_read_i = 1'b0;
    logic        avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [3:0]  avs_byteenable_i = 4'hf;
    logic [31:0] avs_readdata_o, q;
    logic [19:0] tx_data_o, rx_data_i;
    logic [1:0]  tx_k_o, rx_k_i;
    logic        avs_waitrequest_o, tx_slot_i, tx_valid_o, tx_oe_o, rx_valid_i, cal_ovr_en_o, cal_latch_o;
    logic [2:0]  cal_sel_o;
    logic [7:0]  cal_value_i = 8'h3c;
    logic [7:0]  cal_value_o;
    logic        slow = 1'b0;
    logic        corrupt = 1'b0;
    logic [22:0] exp_q[$];
    int          num_errors = 0;
    int          cmp_count = 0;
    int          cycles = 0;
    int          n;

    sblb_bist_lane sblb_bist_lane_inst (.mclk_i, .rst_b_i, .avs_address_i, .avs_read_i, .avs_write_i,
        .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .tx_slot_i, .tx_data_o,
        .tx_k_o, .tx_valid_o, .tx_oe_o, .rx_valid_i, .rx_data_i, .rx_k_i, .cal_value_i, .cal_value_o,
        .cal_sel_o, .cal_ovr_en_o, .cal_latch_o);
    sblb_lane_model sblb_lane_model_inst (.mclk_i, .rst_b_i, .slow_i(slow), .corrupt_i(corrupt),
        .tx_data_i(tx_data_o), .tx_k_i(tx_k_o), .tx_valid_i(tx_valid_o), .tx_oe_i(tx_oe_o),
        .tx_slot_o(tx_slot_i), .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i), .rx_k_o(rx_k_i));

    initial begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end

    task automatic print_verdict;
        if (num_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // hang guard, well above the saturation run
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles > 90000) begin
            num_errors++;
            print_verdict();
        end
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one access, held until waitrequest is sampled low; read data lands in q
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        avs_address_i   <= a;
        avs_write_i     <= wr;
        avs_read_i      <= !wr;
        avs_writedata_i <= d;
        do @(posedge mclk_i); while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i  <= 1'b0;
    endtask

    // restart the engine from idle, then collect cnt words
    task automatic run(input logic [31:0] lane, input logic [31:0] ctl, input int cnt);
        bus(1'b1, OFF_GEN_CTL, 32'h0);
        bus(1'b1, OFF_LANE_CFG, lane);
        sblb_lane_model_inst.words.delete();
        bus(1'b1, OFF_GEN_CTL, ctl);
        while (sblb_lane_model_inst.words.size() < cnt) @(negedge mclk_i);
    endtask

    task automatic cmpq(input string nm);
        foreach (exp_q[i]) chk(nm, 32'(exp_q[i]), 32'(sblb_lane_model_inst.words[i]));
        exp_q.delete();
    endtask

    initial begin
        repeat (10) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        foreach (OFFS[i]) begin
            bus(1'b0, OFFS[i], 32'h0);
            chk("reset_val", 32'h0, q);
        end
        bus(1'b1, OFF_DELAY, 32'hffff_ffff);
        bus(1'b0, OFF_DELAY, 32'h0);
        chk("delay_reg", 32'h0fff_ffff, q);
        bus(1'b1, OFF_CAL_ERR, 32'hffff_ffff);
        bus(1'b0, OFF_CAL_ERR, 32'h0);
        chk("cal_reg", 32'h3fff_0000, q);
        chk("cal_out", 32'h0000_00ff, 32'(cal_value_o));
        chk("cal_latch", 32'h1, 32'(cal_latch_o));
        // upper data bits stored but kept off the analog side
        bus(1'b1, OFF_CAL_ERR, 32'h14b5_0000);
        cal_value_i <= 8'hc3;
        bus(1'b0, OFF_CAL_ERR, 32'h0);
        chk("cal_out", 32'h0000_005a, 32'(cal_value_o));
        chk("cal_en", 32'h1, 32'(cal_ovr_en_o));
        bus(1'b1, OFF_CAL_ERR, 32'h0);
        bus(1'b0, OFF_CAL_ERR, 32'h0);
        chk("cal_out", 32'h0000_00c3, 32'(cal_value_o));
        bus(1'b1, OFF_CAL_SEL, 32'h0000_0005);
        bus(1'b0, OFF_CAL_SEL, 32'h0);
        chk("cal_sel", 32'h5, q);
        chk("cal_sel_out", 32'h5, 32'(cal_sel_o));
        bus(1'b1, OFF_UDP_LO, UDP[31:0]);
        bus(1'b1, OFF_INS_LO, {INS[23:0], UDP[39:32]});
        bus(1'b1, OFF_ENLOW, {16'h0, INS[39:24]});
        bus(1'b1, OFF_DELAY, 32'h0);
        // ten-bit user pattern, enable always on
        for (int i = 0; i < 8; i++) exp_q.push_back({3'b100, 10'h0, UDP[i%4*10+:10]});
        run(32'h00c0_0000, 32'h0000_00a0, 8);
        cmpq("udp10");
        exp_q = '{{3'b100, UDP[19:0]}, {3'b100, UDP[39:20]}};
        run(32'h00c0_0000, 32'h0000_00e0, 2);
        cmpq("udp20");
        // delay four: four pattern words between insertions, even as double words need
        bus(1'b1, OFF_DELAY, 32'h0004_0000);
        for (int i = 0; i < 12; i++) exp_q.push_back({3'b100, 10'h0,
            (i % 6 < 4) ? UDP[i%6*10+:10] : INS[(i%6-4)*10+:10]});
        run(32'h00c0_0000, 32'h1000_00a8, 12);
        cmpq("insert");
        bus(1'b0, OFF_CAL_ERR, 32'h0);
        chk("err_none", 32'h0, q);
        // exactly three bad words on the loop
        corrupt <= 1'b1;
        @(negedge mclk_i);
        n = sblb_lane_model_inst.words.size() + 2;
        while (sblb_lane_model_inst.words.size() < n) @(negedge mclk_i);
        @(posedge mclk_i);
        corrupt <= 1'b0;
        bus(1'b0, OFF_CAL_ERR, 32'h0);
        chk("err_three", 32'h3, q);
        corrupt <= 1'b1;
        repeat (65600) @(posedge mclk_i);
        corrupt <= 1'b0;
        bus(1'b0, OFF_CAL_ERR, 32'h0);
        chk("err_sat", 32'h0000_ffff, q);
        bus(1'b1, OFF_GEN_CTL, 32'h0000_0080);
        bus(1'b0, OFF_CAL_ERR, 32'h0);
        chk("err_clr", 32'h0, q);
        chk("rst_idle", 32'h0, 32'(tx_valid_o));
        bus(1'b1, OFF_GEN_CTL, 32'h0000_0020);
        bus(1'b0, OFF_GEN_CTL, 32'h0);
        chk("en_idle", 32'h0, 32'(tx_valid_o));
        // byte mode with a slow serializer
        slow <= 1'b1;
        for (int i = 0; i < 5; i++) exp_q.push_back({3'b100, 12'h0, UDP[i*8+:8]});
        run(32'h00c1_0000, 32'h0000_00a0, 5);
        cmpq("udp8");
        exp_q = '{{3'b101, 12'h0, 8'hbc}, {3'b100, 12'h0, 8'h5a}};
        run(32'hbcc1_0000, 32'h0800_5aa1, 2);
        cmpq("pream");
        slow <= 1'b0;
        // enable low two words, high three
        bus(1'b1, OFF_ENLOW, {16'h0002, INS[39:24]});
        bus(1'b1, OFF_DELAY, 32'h0000_0003);
        for (int i = 0; i < 10; i++) exp_q.push_back({i % 5 > 1, 2'b00, 10'h0, UDP[i%4*10+:10]});
        run(32'h00c0_0000, 32'h0000_00a0, 10);
        cmpq("duty");
        run(32'h00c4_0000, 32'h0000_00a0, 20);
        // first seven-bit sequence unit from all ones; duty still low on word zero
        chk("prbs_first", 32'h0000_0040, 32'(sblb_lane_model_inst.words[0]));
        bus(1'b0, OFF_CAL_ERR, 32'h0);
        chk("err_prbs", 32'h0, q);
        print_verdict();
    end
endmodule
